// ### verilog/brc_config.sv
// Burst read configuration bank: two 16-bit words, command sequencer and ready output.
// Assumes all flash bus pins and the burst clock are asynchronous to clk.
//
// How it works
// - Two 16-bit configuration words set the read interface parameters.
// - Reset restores every field's default, which means asynchronous reads.
// - A read-back command sequence returns the configuration words on the data bus.
// - Low word bit 15 clear enables synchronous burst reads, set selects async reads.
// - Latency is high bit 0 over low bits 13..11; codes 0..5 give edges 2..7.
// - Latency codes 8..11 put initial data on rising edges 8..11.
// - Other latency codes are reserved and the field resets to 1101.
// - Low word bit 10 sets ready polarity: 0 active low, 1 active high.
// - Low word bit 8 makes ready lead data by one cycle when 0, align when 1.
// - Low bits 2..0 select burst length: continuous, 8, 16 or 32 words.
// - Low bit 3 enables wrap within a linear group and is ignored when continuous.
// - The low word must precede the high word, else the high word write is dropped.
`timescale 1ns/1ps
`default_nettype none
module brc_config (
  input wire logic clk, // System clock, 100 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce_n, // Chip enable pin, active low
  input wire logic we_n, // Write enable pin, active low
  input wire logic oe_n, // Output enable pin, active low
  input wire logic avd_n, // Address valid pin, active low
  input wire logic burst_clk, // Burst clock from the host
  input wire logic [11:0] addr, // Low address pins
  input wire logic [15:0] dq_in, // Data pins, input side
  output logic [15:0] dq_out, // Data pins, output side
  output logic dq_oe, // Data pins driven
  output logic rdy, // Ready pin, polarity as configured
  output logic sync_mode, // Synchronous burst reads enabled
  output logic [3:0] latency_code, // Combined latency field
  output logic [2:0] burst_len, // Burst length code
  output logic wrap_en, // Wrap within group enabled
  output logic [15:0] read_config_word_low, // Low configuration word
  output logic [15:0] read_config_word_high // High configuration word
);

  // Rising clock edge on which initial data is valid
  function automatic logic [3:0] lat_edges(input logic [3:0] code);
    if (code <= brc_pkg::LAT_SHORT_MAX) begin
      lat_edges = code + brc_pkg::LAT_SHORT_BASE;
    end else if (code >= brc_pkg::LAT_LONG_MIN && code <= brc_pkg::LAT_LONG_MAX) begin
      lat_edges = code;
    end else begin
      // Reserved codes fall back to the longest latency, the safe side
      lat_edges = brc_pkg::LAT_FALLBACK;
    end
  endfunction

  // Word offset decode, shared by the write and read-back paths
  function automatic logic ofs_is_high(input logic [7:0] ofs);
    ofs_is_high = (ofs == brc_pkg::HIGH_WORD_OFS);
  endfunction

  function automatic logic ofs_is_low(input logic [7:0] ofs);
    ofs_is_low = (ofs == brc_pkg::LOW_WORD_OFS);
  endfunction

  // Unlock and command cycles match on address and low data byte together
  function automatic logic cmd_hit(input logic [11:0] a, input logic [7:0] d,
                                   input logic [11:0] ea, input logic [7:0] ed);
    cmd_hit = (a == ea) && (d == ed);
  endfunction

  // Two-flop synchronisers; first stage feeds only the second
  logic [4:0] ctl_s1;
  logic [4:0] ctl_s2;
  logic [11:0] addr_s1;
  logic [11:0] addr_s2;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  // One two-stage chain per control pin
  logic [4:0] ctl_pins;
  assign ctl_pins = {burst_clk, avd_n, oe_n, we_n, ce_n};
  for (genvar g = 0; g < 5; g++) begin : g_ctl_sync
    always_ff @(posedge clk) begin
      ctl_s1[g] <= ctl_pins[g];
      ctl_s2[g] <= ctl_s1[g];
    end
  end

  // Bus bits may land a cycle apart; the host keeps them stable around the strobe
  always_ff @(posedge clk) begin
    addr_s1 <= addr;
    addr_s2 <= addr_s1;
  end

  always_ff @(posedge clk) begin
    dq_s1 <= dq_in;
    dq_s2 <= dq_s1;
  end

  logic ce_ok;
  logic we_s;
  logic oe_ok;
  logic avd_low;
  logic bclk_s;
  assign ce_ok = ~ctl_s2[0];
  assign we_s = ctl_s2[1];
  assign oe_ok = ~ctl_s2[2];
  assign avd_low = ~ctl_s2[3];
  assign bclk_s = ctl_s2[4];

  // Edge history for write strobe and burst clock
  logic we_prev;
  logic bclk_prev;
  // Reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge clk) begin
    if (srst) begin
      we_prev <= 1'b1;
    end else begin
      we_prev <= we_s;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bclk_prev <= 1'b0;
    end else begin
      bclk_prev <= bclk_s;
    end
  end

  // A write completes on the rising edge of the write strobe
  logic wr_evt;
  logic bclk_rise;
  assign wr_evt = we_s & ~we_prev & ce_ok;
  assign bclk_rise = bclk_s & ~bclk_prev;

  logic [7:0] wr_data;
  logic [7:0] wr_ofs;
  assign wr_data = dq_s2[7:0];
  assign wr_ofs = addr_s2[7:0];

  // Command sequencer
  brc_pkg::brc_cmd_t cmd_state;
  brc_pkg::brc_cmd_t next_cmd_state;
  always_comb begin
    next_cmd_state = cmd_state;
    if (wr_evt) begin
      case (cmd_state)
        brc_pkg::CMD_IDLE: begin
          if (cmd_hit(addr_s2, wr_data, brc_pkg::UNLOCK1_ADDR, brc_pkg::UNLOCK1_DATA)) begin
            next_cmd_state = brc_pkg::CMD_UNLOCKED1;
          end
        end
        brc_pkg::CMD_UNLOCKED1: begin
          if (cmd_hit(addr_s2, wr_data, brc_pkg::UNLOCK2_ADDR, brc_pkg::UNLOCK2_DATA)) begin
            next_cmd_state = brc_pkg::CMD_UNLOCKED2;
          end else begin
            next_cmd_state = brc_pkg::CMD_IDLE;
          end
        end
        brc_pkg::CMD_UNLOCKED2: begin
          if (cmd_hit(addr_s2, wr_data, brc_pkg::UNLOCK1_ADDR, brc_pkg::CFG_WRITE_CMD)) begin
            next_cmd_state = brc_pkg::CMD_CFG_DATA;
          end else if (cmd_hit(addr_s2, wr_data, brc_pkg::UNLOCK1_ADDR,
                               brc_pkg::CFG_READ_CMD)) begin
            next_cmd_state = brc_pkg::CMD_CFG_READ;
          end else begin
            next_cmd_state = brc_pkg::CMD_IDLE;
          end
        end
        brc_pkg::CMD_CFG_DATA: begin
          next_cmd_state = brc_pkg::CMD_IDLE;
        end
        brc_pkg::CMD_CFG_READ: begin
          // Read-back mode is left only by the software reset command
          if (wr_data == brc_pkg::SOFT_RESET_CMD) begin
            next_cmd_state = brc_pkg::CMD_IDLE;
          end
        end
        default: begin
          next_cmd_state = brc_pkg::CMD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_state <= brc_pkg::CMD_IDLE;
    end else begin
      cmd_state <= next_cmd_state;
    end
  end

  // Configuration words
  logic cfg_wr;
  logic low_armed;
  assign cfg_wr = wr_evt && cmd_state == brc_pkg::CMD_CFG_DATA;

  always_ff @(posedge clk) begin
    if (srst) begin
      read_config_word_low <= brc_pkg::LOW_RESET;
    end else if (cfg_wr && ofs_is_low(wr_ofs)) begin
      read_config_word_low <= dq_s2;
    end
  end

  // High word without a preceding low word is dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      read_config_word_high <= brc_pkg::HIGH_RESET;
    end else if (cfg_wr && ofs_is_high(wr_ofs) && low_armed) begin
      read_config_word_high <= dq_s2;
    end
  end

  // Arms on a low write, disarms once a high write has been seen
  always_ff @(posedge clk) begin
    if (srst) begin
      low_armed <= 1'b0;
    end else if (cfg_wr && ofs_is_low(wr_ofs)) begin
      low_armed <= 1'b1;
    end else if (cfg_wr && ofs_is_high(wr_ofs)) begin
      low_armed <= 1'b0;
    end
  end

  logic [15:0] lw;
  logic [15:0] hw;
  logic pol_high;
  logic rdy_with_data;
  assign lw = read_config_word_low;
  assign hw = read_config_word_high;
  assign sync_mode = ~lw[brc_pkg::MODE_BIT];
  assign latency_code = {hw[brc_pkg::LAT_MSB_BIT], lw[brc_pkg::LAT_HI:brc_pkg::LAT_LO]};
  assign pol_high = lw[brc_pkg::POL_BIT];
  assign rdy_with_data = lw[brc_pkg::TIMING_BIT];
  assign burst_len = lw[brc_pkg::BLEN_HI:0];
  // Wrap has no meaning in continuous mode
  assign wrap_en = lw[brc_pkg::WRAP_BIT] & (lw[brc_pkg::BLEN_HI:0] != 3'b000);

  // Read-back of the configuration words
  always_ff @(posedge clk) begin
    if (srst) begin
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
    end else begin
      dq_oe <= 1'b0;
      dq_out <= 16'h0000;
      if (cmd_state == brc_pkg::CMD_CFG_READ && ce_ok && oe_ok && we_s) begin
        dq_oe <= 1'b1;
        if (ofs_is_high(addr_s2[7:0])) begin
          dq_out <= hw;
        end else begin
          dq_out <= lw;
        end
      end
    end
  end

  // Count burst clock edges after the address is latched
  logic [3:0] edge_cnt;
  logic in_burst;
  always_ff @(posedge clk) begin
    if (srst) begin
      edge_cnt <= 4'h0;
      in_burst <= 1'b0;
    end else if (!ce_ok) begin
      edge_cnt <= 4'h0;
      in_burst <= 1'b0;
    end else if (bclk_rise) begin
      if (avd_low) begin
        // Address latched on this edge; counting restarts
        edge_cnt <= 4'h0;
        in_burst <= sync_mode;
      end else if (in_burst && edge_cnt != 4'hF) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  // Ready leads data by one edge when early timing is chosen
  logic [3:0] due;
  logic ready_now;
  always_comb begin
    due = lat_edges(latency_code);
    if (!rdy_with_data) begin
      due = due - 4'h1;
    end
    // Async mode never inserts wait states, so ready stays active
    ready_now = !in_burst || (edge_cnt >= due);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdy <= 1'b1;
    end else begin
      rdy <= pol_high ? ready_now : ~ready_now;
    end
  end

endmodule // brc_config
`default_nettype wire

// ### verilog/brc_pkg.sv
// Constants and types for the burst read configuration bank.
// Assumes a 16-bit flash data bus and 12 decoded low address bits.
package brc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  // Reset images of the two configuration words
  localparam logic [15:0] LOW_RESET = 16'hEFC8;
  localparam logic [15:0] HIGH_RESET = 16'hFFEF;
  // Field positions in the low word
  localparam int MODE_BIT = 15;
  localparam int LAT_HI = 13;
  localparam int LAT_LO = 11;
  localparam int POL_BIT = 10;
  localparam int TIMING_BIT = 8;
  localparam int WRAP_BIT = 3;
  localparam int BLEN_HI = 2;
  // Field position in the high word
  localparam int LAT_MSB_BIT = 0;
  // Command sequence addresses and data
  localparam logic [11:0] UNLOCK1_ADDR = 12'h0555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h02AA;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CFG_WRITE_CMD = 8'hD0;
  localparam logic [7:0] CFG_READ_CMD = 8'hC6;
  localparam logic [7:0] SOFT_RESET_CMD = 8'hF0;
  localparam logic [7:0] LOW_WORD_OFS = 8'h00;
  localparam logic [7:0] HIGH_WORD_OFS = 8'h01;
  // Latency decoding
  localparam logic [3:0] LAT_SHORT_MAX = 4'h5;
  localparam logic [3:0] LAT_LONG_MIN = 4'h8;
  localparam logic [3:0] LAT_LONG_MAX = 4'hB;
  localparam logic [3:0] LAT_SHORT_BASE = 4'h2;
  localparam logic [3:0] LAT_FALLBACK = 4'hB;
  typedef enum logic [2:0] {
    CMD_IDLE,
    CMD_UNLOCKED1,
    CMD_UNLOCKED2,
    CMD_CFG_DATA,
    CMD_CFG_READ
  } brc_cmd_t;
endpackage

// ### bench/brc_config_chk.sv
// Port checker for the configuration bank.
// Assumes it is bound onto brc_config; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module brc_config_chk (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic ce_n, // Chip enable
  input wire logic oe_n, // Output enable
  input wire logic dq_oe, // Data driven
  input wire logic rdy, // Ready
  input wire logic sync_mode, // Burst mode
  input wire logic [3:0] latency_code, // Latency
  input wire logic [2:0] burst_len, // Length
  input wire logic wrap_en, // Wrap
  input wire logic [15:0] read_config_word_low, // Low word
  input wire logic [15:0] read_config_word_high // High word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [15:0] lo;
  logic [15:0] hi;
  assign lo = read_config_word_low;
  assign hi = read_config_word_high;
  sequence s_async_hold;
    (!sync_mode && lo[10]) [*4];
  endsequence
  sequence s_read_pins;
    $past(oe_n, 2) == 1'b0 && $past(ce_n, 2) == 1'b0;
  endsequence
  a_reset_words: assert property ($fell(srst) |-> lo == brc_pkg::LOW_RESET
    && hi == brc_pkg::HIGH_RESET) else $error("words not at reset value");
  a_reset_pins: assert property ($fell(srst) |-> rdy && !dq_oe
    && latency_code == 4'hD) else $error("pins not at reset value");
  a_mode_bit: assert property (sync_mode == !lo[15])
    else $error("mode does not follow word");
  a_latency_map: assert property (latency_code == {hi[0], lo[13:11]})
    else $error("latency field misplaced");
  a_burst_length: assert property (burst_len == lo[2:0])
    else $error("burst length misplaced");
  a_wrap_gate: assert property (wrap_en == (lo[3] && lo[2:0] != 3'h0))
    else $error("wrap not gated by length");
  a_async_ready: assert property (s_async_hold |-> rdy)
    else $error("ready inactive in async mode");
  a_read_drive: assert property ($rose(dq_oe) |-> s_read_pins)
    else $error("data driven without read");
endmodule // brc_config_chk
bind brc_config brc_config_chk u_chk (.clk(clk), .srst(srst), .ce_n(ce_n), .oe_n(oe_n),
  .dq_oe(dq_oe), .rdy(rdy), .sync_mode(sync_mode), .latency_code(latency_code),
  .burst_len(burst_len), .wrap_en(wrap_en), .read_config_word_low(read_config_word_low),
  .read_config_word_high(read_config_word_high));
`default_nettype wire

// ### bench/brc_host.sv
// Host controller model driving the flash pins and burst clock.
// Assumes the bench clock; pins move at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module brc_host (
  input wire logic clk, // Clock
  input wire logic rdy, // Ready
  input wire logic [15:0] dq_out, // Read data
  input wire logic dq_oe, // Read driven
  output logic ce_n, // Chip enable
  output logic we_n, // Write strobe
  output logic oe_n, // Output enable
  output logic avd_n, // Address valid
  output logic burst_clk, // Burst clock
  output logic [11:0] addr, // Address
  output logic [15:0] dq_in // Write data
);
  initial begin
    {ce_n, we_n, oe_n, avd_n, burst_clk, addr, dq_in} = {5'h1E, 12'h000, 16'h0000};
  end
  task wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    {addr, dq_in, ce_n, we_n} = {a, d, 2'h0};
    repeat (5) @(negedge clk);
    we_n = 1'b1;
    repeat (5) @(negedge clk);
    // Released lines must not keep the old value
    {ce_n, dq_in} = {1'b1, ~d};
  endtask
  task cmd(input logic [7:0] c);
    wr(brc_pkg::UNLOCK1_ADDR, {8'h00, brc_pkg::UNLOCK1_DATA});
    wr(brc_pkg::UNLOCK2_ADDR, {8'h00, brc_pkg::UNLOCK2_DATA});
    wr(brc_pkg::UNLOCK1_ADDR, {8'h00, c});
  endtask
  task cfg(input logic [7:0] ofs, input logic [15:0] v);
    cmd(brc_pkg::CFG_WRITE_CMD);
    wr({4'h7, ofs}, v);
  endtask
  task rd(input logic [7:0] ofs, output logic [15:0] d);
    cmd(brc_pkg::CFG_READ_CMD);
    @(negedge clk);
    {addr, ce_n, oe_n} = {4'h0, ofs, 2'h0};
    repeat (6) @(negedge clk);
    d = (dq_oe === 1'b1) ? dq_out : 16'hxxxx;
    {ce_n, oe_n} = 2'h3;
    wr(12'h555, {8'h00, brc_pkg::SOFT_RESET_CMD});
  endtask
  // Clock runs only inside the burst frame
  task burst(input logic pol, output int k);
    k = -1;
    @(negedge clk);
    {ce_n, avd_n} = 2'h0;
    for (int i = 0; i < 14; i++) begin
      repeat (8) @(negedge clk);
      burst_clk = 1'b1;
      repeat (8) @(negedge clk);
      {burst_clk, avd_n} = 2'h1;
      if (k < 0 && rdy === pol) k = i;
    end
    ce_n = 1'b1;
  endtask
endmodule // brc_host
`default_nettype wire

// ### bench/brc_config_tb.sv
// Self-checking bench for the configuration bank.
// Assumes brc_host drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module brc_config_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce_n, we_n, oe_n, avd_n, burst_clk, dq_oe, rdy, sync_mode, wrap_en;
  logic [11:0] addr;
  logic [15:0] dq_in, dq_out, lo, hi, d, v;
  logic [3:0] latency_code;
  logic [2:0] burst_len;
  logic [3:0] codes [5] = '{4'h0, 4'h5, 4'h8, 4'hB, 4'h3};
  logic [2:0] blens [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h2};
  int bad_count = 0, comparisons = 0, cycles = 0, k, exp_k;
  brc_config uut (.clk, .srst, .ce_n, .we_n, .oe_n, .avd_n, .burst_clk, .addr, .dq_in,
    .dq_out, .dq_oe, .rdy, .sync_mode, .latency_code, .burst_len, .wrap_en,
    .read_config_word_low(lo), .read_config_word_high(hi));
  brc_host host (.clk, .rdy, .dq_out, .dq_oe, .ce_n, .we_n, .oe_n, .avd_n, .burst_clk,
    .addr, .dq_in);
  always #5 clk = ~clk;
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      test_done();
    end
  end
  task chk_defaults;
    `CHK("low word", brc_pkg::LOW_RESET, lo)
    `CHK("high word", brc_pkg::HIGH_RESET, hi)
    `CHK("sync mode", 1'b0, sync_mode)
    `CHK("latency", 4'hD, latency_code)
    `CHK("async ready", 1'b1, rdy)
    host.rd(8'h00, d);
    `CHK("readback low", brc_pkg::LOW_RESET, d)
    host.rd(8'h01, d);
    `CHK("readback high", brc_pkg::HIGH_RESET, d)
  endtask
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk_defaults();
    host.cfg(8'h01, 16'hFFEE);
    repeat (4) @(negedge clk);
    `CHK("high out of order", brc_pkg::HIGH_RESET, hi)
    `CHK("low out of order", brc_pkg::LOW_RESET, lo)
    for (int i = 0; i < 5; i++) begin
      // Reserved bits kept at their defaults; only listed latency codes
      v = {2'h1, codes[i][2:0], i[0], 1'b1, i[1], 4'hC, i != 4, blens[i]};
      host.cfg(8'h00, v);
      host.cfg(8'h01, {15'h7FF7, codes[i][3]});
      repeat (4) @(negedge clk);
      `CHK("sync mode", 1'b1, sync_mode)
      `CHK("latency", codes[i], latency_code)
      `CHK("burst length", blens[i], burst_len)
      `CHK("wrap", blens[i] != 0 && i != 4, wrap_en)
      exp_k = (codes[i] < 8 ? codes[i] + 2 : codes[i]) - (i[1] ? 0 : 1);
      host.burst(i[0], k);
      `CHK("ready edge", exp_k, k)
    end
    host.rd(8'h01, d);
    `CHK("readback high", 16'hFFEE, d)
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk_defaults();
    test_done();
  end
endmodule // brc_config_tb
`default_nettype wire
